// [hdl/rbd_cfg.svh]
// Constants for the reset, strap and address-decode block.
// Assumes one 10 MHz master clock; included by bare name.
`ifndef RBD_CFG_SVH
`define RBD_CFG_SVH
`define RBD_CLK_PERIOD_NS   100
`define RBD_FETCH_DELAY_CYC 80
`define RBD_PIN_START_CYC   3
`define RBD_STRAP_WIN_CYC   10
`define RBD_INT_TOP         32'h003f_ffff
`define RBD_PERIPH_BASE     32'hffc0_0000
`define RBD_SRAM_BYTES      8192
`define RBD_VEC_TOP         32'h0000_0020
`endif

// [hdl/rbd_pkg.sv]
// Types shared by the reset, strap and address-decode block.
// Assumes nothing beyond the cfg header.
package rbd_pkg;
  typedef enum logic [1:0] {
    RBD_REG_INTERNAL,
    RBD_REG_EXTERNAL,
    RBD_REG_PERIPH
  } rbd_region_type;
endpackage

// [hdl/rbd_sram.sv]
// Internal 8K-byte SRAM, 32 bits wide, byte-lane writes, one-cycle access.
// Assumes the decoder drives a word address and a select on the same clock.
`timescale 1ns/1ns
`include "rbd_cfg.svh"
module rbd_sram #(
  parameter int BYTES = `RBD_SRAM_BYTES
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_sel,
  input  wire logic                       i_write,
  input  wire logic [3:0]                 i_lane,
  input  wire logic [$clog2(BYTES/4)-1:0] i_word,
  input  wire logic [31:0]                i_wdata,
  output logic      [31:0]                o_rdata
);
  // One byte array per lane, so each lane process owns its own storage
  logic [7:0]  mem [4][BYTES/4];
  logic [31:0] rdata;
  // Byte lanes are little-endian: lane 0 is bits 7:0
  always_ff @(posedge i_clock) begin
    if (i_sel) begin
      rdata <= {mem[3][i_word], mem[2][i_word], mem[1][i_word], mem[0][i_word]};
    end
  end
  for (genvar b = 0; b < 4; b++) begin : g_lane
    always_ff @(posedge i_clock) begin
      if (i_sel && i_write && i_lane[b]) begin
        mem[b][i_word] <= i_wdata[8*b +: 8];
      end
    end
  end
  assign o_rdata = rdata;
endmodule

// [hdl/rbd_top.sv]
// Reset sequencing, strap capture, clock output and top-level address decode.
// Assumes i_ext_reset_n and straps are board pins; the bus comes from the core.
`timescale 1ns/1ns
`include "rbd_cfg.svh"
// Functional notes
// - Pin reset asserts asynchronously, releases on clock edge; watchdog reset asserts on a clock edge
// - First fetch 80 cycles after pin rise
// - Every reset restores defaults except that watchdog reset keeps strap modes, fetch from zero
// - Clock output low in reset, then copy; o_clock_out_gate low, o_clock_out_oe_n high, in pin reset and in float mode, not in watchdog reset
// - Watchdog reset keeps latched strap modes
// - Pin reset wins over watchdog reset
// - Strap low last 10 cycles enters float
// - Float mode disables every output driver
// - Boot width from strap, last 10 cycles
// - High strap 8-bit boot, low 16-bit
// - Peripheral pins are inputs after reset
// - Decode internal, external, peripheral regions
// - Little-endian only, no big-endian mode
// - 8K SRAM single-cycle byte/half/word access
// - After remap SRAM sits at zero
// - Before remap zero decodes boot memory
// - Remap cleared only by reset
module rbd_top
  import rbd_pkg::*;
#(
  parameter int FETCH_DELAY = `RBD_FETCH_DELAY_CYC,
  parameter int STRAP_WIN   = `RBD_STRAP_WIN_CYC,
  parameter int PIO_WIDTH   = 32
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ext_reset_n,
  input  wire logic                 i_wdog_reset,
  input  wire logic                 i_boot_width_strap,
  input  wire logic                 i_float_outputs_strap_n,
  input  wire logic                 i_clock_out_reassign,
  input  wire logic                 i_remap_cmd,
  input  wire logic                 i_bus_valid,
  input  wire logic                 i_bus_write,
  input  wire logic [1:0]           i_bus_size,
  input  wire logic [31:0]          i_bus_addr,
  input  wire logic [31:0]          i_bus_wdata,
  output logic                      o_core_reset,
  output logic                      o_fetch_enable,
  output logic                      o_clock_out_gate,
  output logic                      o_clock_out_oe_n,
  output logic                      o_float_mode,
  output logic                      o_boot_8bit,
  output logic                      o_remapped,
  output logic                      o_pio_input_mode,
  output logic [PIO_WIDTH-1:0]      o_pio_oe_n,
  output logic                      o_sel_sram,
  output logic                      o_sel_boot,
  output logic                      o_sel_external,
  output logic                      o_sel_periph,
  output logic [31:0]               o_sram_rdata
);
  localparam int CW = $clog2(FETCH_DELAY + 1);
  localparam int SW = $clog2(STRAP_WIN + 1);
  localparam int AW = $clog2(`RBD_SRAM_BYTES / 4);

  // Pin inputs: two flops each; the first flop feeds only the second
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {i_ext_reset_n, i_boot_width_strap, i_float_outputs_strap_n};
      sync2 <= sync1;
    end
  end
  wire pin_n   = sync2[2];
  wire width_s = sync2[1];
  wire float_s = sync2[0];

  // Pin reset: async assert, clocked release
  logic pin_rst_q;
  logic pin_rst_q2;
  always_ff @(posedge i_clock or negedge i_ext_reset_n) begin
    if (!i_ext_reset_n) begin
      pin_rst_q  <= 1'h1;
      pin_rst_q2 <= 1'h1;
    end else begin
      pin_rst_q  <= 1'h0;
      pin_rst_q2 <= pin_rst_q;
    end
  end
  wire pin_rst = pin_rst_q2 | ~i_rst_n;

  // Sequencer state: delay counter, strap window counters, captured modes
  logic [CW-1:0] cnt;
  logic [SW-1:0] lo_run;
  logic [SW-1:0] hi_run;
  logic          pin_prev;
  logic          core_reset;
  logic          fetch_en;
  logic          float_mode;
  logic          boot_8bit;
  logic          remapped;
  logic [CW-1:0] next_cnt;
  logic [SW-1:0] next_lo_run;
  logic [SW-1:0] next_hi_run;
  logic          next_core_reset;
  logic          next_fetch_en;
  logic          next_float_mode;
  logic          next_boot_8bit;
  logic          next_remapped;

  // Counting from the synchronised pin rise: the first count comes three
  // edges after the real edge, so the counter starts there to keep the
  // fetch exactly FETCH_DELAY cycles from the pin rise.
  always_comb begin
    next_cnt        = cnt;
    next_lo_run     = lo_run;
    next_hi_run     = hi_run;
    next_core_reset = core_reset;
    next_fetch_en   = fetch_en;
    next_float_mode = float_mode;
    next_boot_8bit  = boot_8bit;
    next_remapped   = remapped;
    if (!pin_n) begin
      // Strap windows track the last cycles while the pin is low
      next_lo_run  = (!float_s && lo_run < SW'(STRAP_WIN)) ? lo_run + 1'b1
                   : (float_s ? '0 : lo_run);
      next_hi_run  = (width_s && hi_run < SW'(STRAP_WIN)) ? hi_run + 1'b1
                   : (width_s ? hi_run : '0);
    end
    if (pin_n && !pin_prev) begin
      // Pin release: capture straps; watchdog never reaches here
      next_float_mode = (lo_run >= SW'(STRAP_WIN));
      next_boot_8bit  = (hi_run >= SW'(STRAP_WIN));
      next_lo_run     = '0;
      next_hi_run     = '0;
    end
    if (i_wdog_reset && !pin_rst) begin
      next_cnt        = CW'(2); // modes kept
      next_core_reset = 1'b1;
      next_fetch_en   = 1'b0;
      next_remapped   = 1'b0;
    end else if (pin_rst || !pin_n) begin
      next_cnt        = CW'(`RBD_PIN_START_CYC);
      next_core_reset = 1'b1;
      next_fetch_en   = 1'b0;
      next_remapped   = 1'b0;
    end else if (core_reset) begin
      next_cnt = cnt + 1'b1;
      if (cnt >= CW'(FETCH_DELAY - 1)) begin
        next_core_reset = 1'b0;
        next_fetch_en   = 1'b1;
      end
    end else if (i_remap_cmd) begin
      next_remapped = 1'b1; // set only
    end
  end

  // Registers; pin reset takes precedence through the async clear
  always_ff @(posedge i_clock or posedge pin_rst) begin
    if (pin_rst) begin
      cnt         <= CW'(`RBD_PIN_START_CYC);
      core_reset  <= 1'h1;
      fetch_en    <= 1'h0;
      remapped    <= 1'h0;
      pin_prev    <= 1'h0;
    end else begin
      cnt         <= next_cnt;
      core_reset  <= next_core_reset;
      fetch_en    <= next_fetch_en;
      remapped    <= next_remapped;
      pin_prev    <= pin_n;
    end
  end

  // Strap state survives pin reset so the window can be watched during it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_run     <= '0;
      hi_run     <= '0;
      float_mode <= 1'h0;
      boot_8bit  <= 1'h0;
    end else begin
      lo_run     <= next_lo_run;
      hi_run     <= next_hi_run;
      float_mode <= next_float_mode;
      boot_8bit  <= next_boot_8bit;
    end
  end

  // Address decode, combinational, registered below for flop-driven outputs
  rbd_region_type region;
  logic           hit_zero;
  logic [3:0]     lane;
  always_comb begin
    if (i_bus_addr <= `RBD_INT_TOP) begin
      region = RBD_REG_INTERNAL;
    end else if (i_bus_addr >= `RBD_PERIPH_BASE) begin
      region = RBD_REG_PERIPH;
    end else begin
      region = RBD_REG_EXTERNAL;
    end
    hit_zero = (i_bus_addr < 32'(`RBD_SRAM_BYTES));
    // Little-endian lanes only; there is no byte-swap path at all
    case (i_bus_size)
      2'h0:    lane = 4'h1 << i_bus_addr[1:0];
      2'h1:    lane = i_bus_addr[1] ? 4'hc : 4'h3;
      default: lane = 4'hf;
    endcase
  end

  wire ok     = i_bus_valid && !core_reset;
  wire to_ram = ok && region == RBD_REG_INTERNAL && hit_zero && remapped;
  wire to_bt  = ok && region == RBD_REG_INTERNAL && !remapped;

  // SRAM: single cycle for every size, including fetches
  rbd_sram u_sram (
    .i_clock (i_clock),
    .i_sel   (to_ram),
    .i_write (i_bus_write),
    .i_lane  (lane),
    .i_word  (i_bus_addr[AW+1:2]),
    .i_wdata (i_bus_wdata),
    .o_rdata (o_sram_rdata)
  );

  // Output flops; float mode forces every output-driver enable off
  always_ff @(posedge i_clock or posedge pin_rst) begin
    if (pin_rst) begin
      o_core_reset     <= 1'h1;
      o_fetch_enable   <= 1'h0;
      o_clock_out_gate <= 1'h0;
      o_clock_out_oe_n <= 1'h1;
      o_float_mode     <= 1'h0;
      o_boot_8bit      <= 1'h0;
      o_remapped       <= 1'h0;
      o_pio_input_mode <= 1'h1;
      o_pio_oe_n       <= '1;
      o_sel_sram       <= 1'h0;
      o_sel_boot       <= 1'h0;
      o_sel_external   <= 1'h0;
      o_sel_periph     <= 1'h0;
    end else begin
      o_core_reset     <= core_reset;
      o_fetch_enable   <= fetch_en;
      o_clock_out_gate <= !i_clock_out_reassign && !float_mode;
      o_clock_out_oe_n <= float_mode;
      o_float_mode     <= float_mode;
      o_boot_8bit      <= boot_8bit;
      o_remapped       <= remapped;
      o_pio_input_mode <= core_reset ? 1'h1 : o_pio_input_mode;
      o_pio_oe_n       <= '1; // pins stay inputs here
      o_sel_sram       <= to_ram;
      o_sel_boot       <= to_bt;
      o_sel_external   <= ok && region == RBD_REG_EXTERNAL;
      o_sel_periph     <= ok && region == RBD_REG_PERIPH;
    end
  end
endmodule

// [tb/rbd_properties.sv]
// Checker for reset sequencing, strap capture and region decode.
// Assumes it is bound into rbd_top and sees only that module's ports.
`timescale 1ns/1ns
module rbd_checker #(
  parameter int FETCH_DELAY = 80,
  parameter int PIO_WIDTH   = 32
) (
  input wire logic                 i_clock,
  input wire logic                 i_rst_n,
  input wire logic                 i_ext_reset_n,
  input wire logic                 i_wdog_reset,
  input wire logic                 i_bus_valid,
  input wire logic [31:0]          i_bus_addr,
  input wire logic                 o_core_reset,
  input wire logic                 o_fetch_enable,
  input wire logic                 o_clock_out_gate,
  input wire logic                 o_clock_out_oe_n,
  input wire logic                 o_float_mode,
  input wire logic                 o_boot_8bit,
  input wire logic                 o_remapped,
  input wire logic [PIO_WIDTH-1:0] o_pio_oe_n,
  input wire logic                 o_sel_sram,
  input wire logic                 o_sel_boot,
  input wire logic                 o_sel_external,
  input wire logic                 o_sel_periph
);
  logic [7:0] cnt;
  logic       wflag;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Cycles since pin release; a watchdog reset spoils the count, so flag it
  always_ff @(posedge i_clock or negedge i_ext_reset_n) begin
    if (!i_ext_reset_n) begin
      cnt   <= 8'h00;
      wflag <= 1'b0;
    end else begin
      cnt   <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
      wflag <= wflag | i_wdog_reset;
    end
  end
  pin_reset_a: assert property (!i_ext_reset_n |-> o_core_reset && !o_fetch_enable)
    else $error("core not held by reset pin");
  fetch_time_a: assert property ($rose(o_fetch_enable) && !wflag |-> cnt == FETCH_DELAY)
    else $error("fetch enable at wrong cycle");
  clock_low_a: assert property (!i_ext_reset_n |-> !o_clock_out_gate)
    else $error("clock pin not low in reset");
  pio_input_a: assert property (!i_ext_reset_n |-> &o_pio_oe_n)
    else $error("peripheral pin driven in reset");
  wdog_reset_a: assert property (i_wdog_reset && i_ext_reset_n |-> ##[1:2] o_core_reset)
    else $error("watchdog did not reset core");
  wdog_keep_a: assert property (i_wdog_reset |=> $stable(o_boot_8bit) && $stable(o_float_mode))
    else $error("watchdog changed strap modes");
  float_drv_a: assert property (o_float_mode |-> o_clock_out_oe_n && &o_pio_oe_n)
    else $error("driver on in float mode");
  remap_hold_a: assert property (o_remapped && i_ext_reset_n && !i_wdog_reset
    && !$past(i_wdog_reset) |=> o_remapped || !i_ext_reset_n)
    else $error("remap lost without reset");
  zero_map_a: assert property (i_bus_valid && !o_core_reset && i_bus_addr == 32'h0 |=>
    o_sel_sram == $past(o_remapped) && o_sel_boot == !$past(o_remapped))
    else $error("wrong memory at address zero");
  periph_a: assert property (i_bus_valid && !o_core_reset && i_bus_addr >= 32'hffc0_0000
    |=> o_sel_periph && !o_sel_external)
    else $error("peripheral region not selected");
  ext_sel_a: assert property (i_bus_valid && !o_core_reset
    && i_bus_addr inside {[32'h0040_0000:32'hffbf_ffff]} |=> o_sel_external && !o_sel_sram)
    else $error("external region not selected");
  cover property ($rose(o_fetch_enable));
  cover property ($rose(o_float_mode));
  cover property ($rose(o_remapped));
endmodule
bind rbd_top rbd_checker #(.FETCH_DELAY(FETCH_DELAY), .PIO_WIDTH(PIO_WIDTH)) chk_u (
  .i_clock, .i_rst_n, .i_ext_reset_n, .i_wdog_reset, .i_bus_valid, .i_bus_addr,
  .o_core_reset, .o_fetch_enable, .o_clock_out_gate, .o_clock_out_oe_n, .o_float_mode,
  .o_boot_8bit, .o_remapped, .o_pio_oe_n, .o_sel_sram, .o_sel_boot, .o_sel_external,
  .o_sel_periph);

// [tb/rbd_board.sv]
// Board model: reset pin source and the two strap pins.
// Assumes the bench calls its tasks at the falling clock edge.
`timescale 1ns/1ns
module rbd_board (
  input  wire logic i_clock,
  output logic      o_ext_reset_n,
  output logic      o_width,
  output logic      o_float_n
);
  // Power-up: pin low, straps at normal levels
  initial begin
    o_ext_reset_n = 1'h0;
    o_width       = 1'h1;
    o_float_n     = 1'h1;
  end
  // Pin pulse; clock already runs and straps stay steady well past the window
  task automatic pulse(input logic w, input logic f);
    @(negedge i_clock);
    o_ext_reset_n = 1'h0;
    o_width       = w;
    o_float_n     = f;
    repeat (12) @(negedge i_clock);
    o_ext_reset_n = 1'h1;
  endtask
  // Straps are plain pins after reset, so show the opposite level
  task automatic flip;
    o_width   = ~o_width;
    o_float_n = ~o_float_n;
  endtask
endmodule

// [tb/reset_boot_strap_decode_bench.sv]
// Bench for rbd_top: boots, strap modes, decode, remap, watchdog, priority.
// Assumes rbd_board drives the reset pin and straps; inputs change at negedge.
`timescale 1ns/1ns
module reset_boot_strap_decode_bench;
  localparam int FD = 8;
  logic        i_clock = 1'h0;
  logic        i_rst_n, i_wdog_reset, i_clock_out_reassign, i_remap_cmd;
  logic        i_bus_valid, i_bus_write;
  logic [1:0]  i_bus_size;
  logic [31:0] i_bus_addr, i_bus_wdata, o_pio_oe_n, o_sram_rdata;
  wire         i_ext_reset_n, i_boot_width_strap, i_float_outputs_strap_n;
  logic        o_core_reset, o_fetch_enable, o_clock_out_gate, o_clock_out_oe_n;
  logic        o_float_mode, o_boot_8bit, o_remapped, o_pio_input_mode;
  logic        o_sel_sram, o_sel_boot, o_sel_external, o_sel_periph;
  int          fail_count = 0;
  int          n_compared = 0;
  always #50 i_clock = ~i_clock;
  rbd_board board_u (.i_clock, .o_ext_reset_n(i_ext_reset_n),
    .o_width(i_boot_width_strap), .o_float_n(i_float_outputs_strap_n));
  rbd_top #(.FETCH_DELAY(FD), .STRAP_WIN(3)) dut_u (.i_clock, .i_rst_n, .i_ext_reset_n,
    .i_wdog_reset, .i_boot_width_strap, .i_float_outputs_strap_n, .i_clock_out_reassign,
    .i_remap_cmd, .i_bus_valid, .i_bus_write, .i_bus_size, .i_bus_addr, .i_bus_wdata,
    .o_core_reset, .o_fetch_enable, .o_clock_out_gate, .o_clock_out_oe_n, .o_float_mode,
    .o_boot_8bit, .o_remapped, .o_pio_input_mode, .o_pio_oe_n, .o_sel_sram, .o_sel_boot,
    .o_sel_external, .o_sel_periph, .o_sram_rdata);
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request; selects and read data are looked at one cycle later
  task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d);
    @(negedge i_clock);
    i_bus_valid = 1'h1;
    i_bus_write = w;
    i_bus_size  = sz;
    i_bus_addr  = a;
    i_bus_wdata = d;
    @(negedge i_clock);
    i_bus_valid = 1'h0;
  endtask
  task automatic boot(input logic w, input logic f);
    int n;
    n = 0;
    board_u.pulse(w, f);
    while (o_fetch_enable !== 1'h1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    chk("fetch delay", FD, n);
    board_u.flip();
    repeat (4) @(negedge i_clock);
    chk("boot width", w, o_boot_8bit);
    chk("float mode", !f, o_float_mode);
    chk("clock pin oe_n", !f, o_clock_out_oe_n);
    chk("clock gate", f, o_clock_out_gate);
    chk("pio oe_n", 32'hffff_ffff, o_pio_oe_n);
    chk("pio input", 1, o_pio_input_mode);
    chk("remapped", 0, o_remapped);
  endtask
  task automatic remap;
    @(negedge i_clock);
    i_remap_cmd = 1'h1;
    @(negedge i_clock);
    i_remap_cmd = 1'h0;
    @(negedge i_clock);
    chk("remapped", 1, o_remapped);
  endtask
  task automatic sweep(input logic rm);
    logic [31:0] a [4];
    logic [3:0]  e [4];
    a = '{32'h0, 32'h0040_0000, 32'hffbf_ffff, 32'hffc0_0000};
    e = '{rm ? 4'h8 : 4'h4, 4'h2, 4'h2, 4'h1};
    for (int i = 0; i < 4; i++) begin
      acc(1'h0, 2'h2, a[i], 32'h0);
      chk("region", e[i], {o_sel_sram, o_sel_boot, o_sel_external, o_sel_periph});
    end
  endtask
  // All four strap combinations, the normal one last
  task automatic t_straps;
    for (int i = 0; i < 4; i++) begin
      boot(i[1], i[0]);
    end
  endtask
  // Decode before and after remap, then mixed-width SRAM writes at zero
  task automatic t_decode;
    sweep(1'h0);
    remap();
    sweep(1'h1);
    acc(1'h1, 2'h2, 32'h0, 32'h4433_2211);
    acc(1'h1, 2'h1, 32'h2, 32'h6655_0000);
    acc(1'h1, 2'h0, 32'h1, 32'h0000_7700);
    acc(1'h0, 2'h2, 32'h0, 32'h0);
    chk("sram word", 32'h6655_7711, o_sram_rdata);
    acc(1'h0, 2'h0, 32'h3, 32'h0);
    chk("sram byte", 32'h66, {24'h0, o_sram_rdata[31:24]});
    // Software takes the clock pin, then hands it back
    i_clock_out_reassign = 1'h1;
    repeat (2) @(negedge i_clock);
    chk("clock gate", 0, o_clock_out_gate);
    i_clock_out_reassign = 1'h0;
    repeat (2) @(negedge i_clock);
    chk("clock gate", 1, o_clock_out_gate);
  endtask
  // Watchdog with straps flipped: modes kept, remap cleared
  task automatic t_wdog;
    boot(1'h0, 1'h1);
    remap();
    @(negedge i_clock);
    i_wdog_reset = 1'h1;
    @(negedge i_clock);
    i_wdog_reset = 1'h0;
    repeat (2) @(negedge i_clock);
    chk("core reset", 1, o_core_reset);
    repeat (40) @(negedge i_clock);
    chk("fetch enable", 1, o_fetch_enable);
    chk("boot width", 0, o_boot_8bit);
    chk("float mode", 0, o_float_mode);
    chk("remapped", 0, o_remapped);
  endtask
  // Pin and watchdog together: the pin wins and straps are taken
  task automatic t_prio;
    i_wdog_reset = 1'h1;
    fork
      boot(1'h1, 1'h1);
      begin
        repeat (4) @(negedge i_clock);
        i_wdog_reset = 1'h0;
      end
    join
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge i_clock);
    fail_count++;
    wrap_up();
  end
  initial begin
    i_rst_n              = 1'h0;
    i_wdog_reset         = 1'h0;
    i_clock_out_reassign = 1'h0;
    i_remap_cmd          = 1'h0;
    i_bus_valid          = 1'h0;
    i_bus_write          = 1'h0;
    i_bus_size           = 2'h0;
    i_bus_addr           = 32'h0;
    i_bus_wdata          = 32'h0;
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'h1;
    t_straps();
    t_decode();
    t_wdog();
    t_prio();
    wrap_up();
  end
endmodule
